// File: common/tsw_pkg.sv
// Constants and types of the time-slot switch host control block
package tsw_pkg;
  localparam logic [5:0]  CTRL_ADDR   = 6'h00;
  localparam logic [5:0]  CTRL_MASK   = 6'h23;
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam int          CTRL_SPLIT  = 7;
  localparam int          CTRL_MSG    = 6;
  localparam int          MS_LSB      = 3;
  localparam int          STA_LSB     = 0;
  localparam logic [1:0]  MS_DM       = 2'h1;
  localparam logic [1:0]  MS_CML      = 2'h2;
  localparam logic [1:0]  MS_CMH      = 2'h3;
  localparam int          CMH_DLY     = 6;
  localparam int          CMH_MSG     = 2;
  localparam int          CMH_CTL     = 1;
  localparam int          CMH_OE      = 0;
  localparam logic [7:0]  MEM_RST     = 8'h00;
  localparam logic [1:0]  BUF_RST     = 2'h0;
  localparam logic [26:0] SYNC_RST    = 27'h0000003;
  localparam logic [5:0]  VAR_GAP     = 6'h02;
  localparam int          CLK_NS      = 4;
  localparam int          ACK_CM_NS   = 800;
  localparam int          ACK_DM_NS   = 1220;
  localparam int          ACK_CM_CYC  = ACK_CM_NS / CLK_NS;
  localparam int          ACK_DM_CYC  = ACK_DM_NS / CLK_NS;
  localparam int          BIT_CYC_DEF = 122;
  localparam int          ACK_WAIT_DEF = 4;
  typedef enum logic [1:0] {
    HP_IDLE = 2'b00,
    HP_BUSY = 2'b01,
    HP_ACK  = 2'b10
  } tsw_hp_state_t;
endpackage

// File: core/tsw_core.sv
// Host port, memories and serial timing of the time-slot switch
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE1: Constant-delay slots received in frame N leave in frame N+2.
// RULE2: Constant delay equals 32 plus (32 minus in slot) plus (out slot minus 1).
// RULE3: Host port: 8-bit data, six address lines, select, strobe, read/write, ack.
// RULE4: Control and both connection memories read/write; data memory read only.
// RULE5: Ack within 800 ns for connection memory, 1220 ns for data memory.
// RULE6: Host waits for the acknowledge before ending each cycle.
// RULE7: Address bits 5, 1 and 0 all low select the control register.
// RULE8: Address bit 5 high selects one of 32 channel locations.
// RULE9: Split bit set: reads go to data memory, writes to connection low.
// RULE10: Memory select 01 data, 10 connection low, 11 connection high.
// RULE11: Stream select picks the 32-location subsection of the chosen memory.
// RULE12: Message override forces message mode and drive enable on every slot.
// RULE13: Per-slot message bit sends connection low; else it addresses data memory.
// RULE14: Output disable pin low floats all outputs; else per-slot enable rules. Code floats only the serial data outputs; control output stays driven.
// RULE15: Control bit of every connection high entry shifts out, 256 per frame.
// RULE16: Control output leads its slot by one channel, stream order per bit.
// RULE17: Each output slot picks variable or constant delay on its own.
// RULE18: Delay bit is connection high bit 6; high means constant delay.
// RULE19: Connection low bits 7-5 source stream, bits 4-0 source channel.
// RULE20: A cleared control bit goes out low.
// RULE21: Location is stream select times 32 plus low five address bits.
module tsw_core #(
  parameter int BIT_CYC  = tsw_pkg::BIT_CYC_DEF,
  parameter int ACK_WAIT = tsw_pkg::ACK_WAIT_DEF
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_clk_en,
  input  wire logic       i_frame_pulse,
  input  wire logic [7:0] i_ser_in,
  input  wire logic       i_global_output_disable,
  input  wire logic       i_cs_n,
  input  wire logic       i_ds_n,
  input  wire logic       i_rw,
  input  wire logic [5:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_transfer_ack,
  output logic      [7:0] o_ser_out,
  output logic      [7:0] o_ser_oe,
  output logic            o_serial_control_out
);
  localparam int CW = $clog2(BIT_CYC);

  function automatic logic [1:0] inc3(input logic [1:0] b);
    inc3 = (b == 2'h2) ? 2'h0 : b + 2'h1;
  endfunction

  // Pin synchronisers
  logic [26:0] s1_q;
  logic [26:0] s2_q;
  logic [26:0] s3_q;
  logic [26:0] flt_q;
  logic [26:0] flt_d;
  logic        fp_prev_q;
  logic        cs_f;
  logic        ds_f;
  logic        fp_f;
  logic        ode_f;
  logic [7:0]  ser_f;
  logic [5:0]  addr_f;
  logic        rw_f;
  logic [7:0]  data_f;

  always_comb begin
    flt_d = flt_q;
    for (int i = 0; i < 27; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        flt_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s1_q      <= tsw_pkg::SYNC_RST;
      s2_q      <= tsw_pkg::SYNC_RST;
      s3_q      <= tsw_pkg::SYNC_RST;
      flt_q     <= tsw_pkg::SYNC_RST;
      fp_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      s1_q      <= {i_data, i_rw, i_addr, i_ser_in,
                    i_global_output_disable, i_frame_pulse, i_ds_n, i_cs_n};
      s2_q      <= s1_q;
      s3_q      <= s2_q;
      flt_q     <= flt_d;
      fp_prev_q <= fp_f;
    end
  end

  assign cs_f   = flt_q[0];
  assign ds_f   = flt_q[1];
  assign fp_f   = flt_q[2];
  assign ode_f  = flt_q[3];
  assign ser_f  = flt_q[11:4];
  assign addr_f = flt_q[17:12];
  assign rw_f   = flt_q[18];
  assign data_f = flt_q[26:19];

  // Bit, slot and frame-buffer timing
  logic [CW-1:0] cyc_q;
  logic [CW-1:0] cyc_d;
  logic [2:0]    bit_q;
  logic [2:0]    bit_d;
  logic [4:0]    slot_q;
  logic [4:0]    slot_d;
  logic [1:0]    wbuf_q;
  logic [1:0]    wbuf_d;
  logic          bit_end;
  logic          mid;
  logic          slot_end;
  logic          fp_rise;

  assign bit_end  = (cyc_q == CW'(BIT_CYC - 1));
  assign mid      = (cyc_q == CW'(BIT_CYC / 2));
  assign slot_end = bit_end && (bit_q == 3'h7);
  assign fp_rise  = fp_f && !fp_prev_q;

  always_comb begin
    cyc_d  = cyc_q + 1'b1;
    bit_d  = bit_q;
    slot_d = slot_q;
    wbuf_d = wbuf_q;
    if (bit_end) begin
      cyc_d = '0;
      bit_d = bit_q + 3'h1;
      if (bit_q == 3'h7) begin
        slot_d = slot_q + 5'h01;
        if (slot_q == 5'h1F) begin
          wbuf_d = inc3(wbuf_q); // [RULE1]
        end
      end
    end
    // Realign on the frame pulse; no extra rotation if already at slot 0
    if (fp_rise) begin
      cyc_d  = '0;
      bit_d  = '0;
      slot_d = '0;
      if (slot_q != 5'h00) begin
        wbuf_d = inc3(wbuf_q);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cyc_q  <= '0;
      bit_q  <= 3'h0;
      slot_q <= 5'h00;
      wbuf_q <= tsw_pkg::BUF_RST;
    end else if (i_clk_en) begin
      cyc_q  <= cyc_d;
      bit_q  <= bit_d;
      slot_q <= slot_d;
      wbuf_q <= wbuf_d;
    end
  end

  // Host port and connection memories
  tsw_pkg::tsw_hp_state_t hp_q;
  tsw_pkg::tsw_hp_state_t hp_d;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] cml_q [256];
  logic [7:0] cml_d [256];
  logic [7:0] cmh_q [256];
  logic [7:0] cmh_d [256];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rd_q;
  logic       rd_d;
  logic [7:0] dm_q [3][256];
  logic [7:0] midx;
  logic [1:0] ms;
  logic       strobe;

  assign strobe = !cs_f && !ds_f;
  assign ms     = ctrl_q[tsw_pkg::MS_LSB +: 2];
  assign midx   = {ctrl_q[tsw_pkg::STA_LSB +: 3], addr_f[4:0]}; // [RULE21] [RULE11]

  always_comb begin
    hp_d    = hp_q;
    cnt_d   = cnt_q;
    ctrl_d  = ctrl_q;
    cml_d   = cml_q;
    cmh_d   = cmh_q;
    rdata_d = rdata_q;
    rd_d    = rd_q;
    case (hp_q)
      tsw_pkg::HP_IDLE: begin
        if (strobe) begin
          hp_d  = tsw_pkg::HP_BUSY;
          cnt_d = 9'h000;
        end
      end
      tsw_pkg::HP_BUSY: begin
        cnt_d = cnt_q + 9'h001;
        if (!strobe) begin
          hp_d = tsw_pkg::HP_IDLE;
        end else if (cnt_q == 9'(ACK_WAIT - 1)) begin
          hp_d    = tsw_pkg::HP_ACK; // [RULE5]
          rd_d    = rw_f;
          rdata_d = 8'h00;
          if ((addr_f & tsw_pkg::CTRL_MASK) == tsw_pkg::CTRL_ADDR) begin // [RULE7]
            if (rw_f) begin
              rdata_d = ctrl_q;
            end else begin
              ctrl_d = data_f;
            end
          end else if (addr_f[5]) begin // [RULE8]
            if (rw_f) begin
              if (ctrl_q[tsw_pkg::CTRL_SPLIT] || ms == tsw_pkg::MS_DM) begin // [RULE9] [RULE10]
                rdata_d = dm_q[wbuf_q][midx];
              end else if (ms == tsw_pkg::MS_CML) begin
                rdata_d = cml_q[midx];
              end else if (ms == tsw_pkg::MS_CMH) begin
                rdata_d = cmh_q[midx];
              end
            end else if (ctrl_q[tsw_pkg::CTRL_SPLIT] || ms == tsw_pkg::MS_CML) begin // [RULE9]
              cml_d[midx] = data_f;
            end else if (ms == tsw_pkg::MS_CMH) begin
              cmh_d[midx] = data_f;
            end
            // Data memory writes dropped: read only from the host [RULE4]
          end
        end
      end
      tsw_pkg::HP_ACK: begin
        // Held until the host drops the strobe [RULE6]
        if (!strobe) begin
          hp_d = tsw_pkg::HP_IDLE;
        end
      end
      default: begin
        hp_d = tsw_pkg::HP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hp_q    <= tsw_pkg::HP_IDLE;
      cnt_q   <= 9'h000;
      ctrl_q  <= tsw_pkg::CTRL_RST;
      rdata_q <= 8'h00;
      rd_q    <= 1'b0;
      for (int i = 0; i < 256; i++) begin
        cml_q[i] <= tsw_pkg::MEM_RST;
        cmh_q[i] <= tsw_pkg::MEM_RST;
      end
    end else if (i_clk_en) begin
      hp_q    <= hp_d;
      cnt_q   <= cnt_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      rd_q    <= rd_d;
      cml_q   <= cml_d;
      cmh_q   <= cmh_d;
    end
  end

  assign o_transfer_ack = (hp_q == tsw_pkg::HP_ACK); // [RULE3]
  assign o_data_oe      = (hp_q == tsw_pkg::HP_ACK) && rd_q;
  assign o_data         = rdata_q;

  // Serial data path: three frame buffers, one written per frame
  logic [7:0][7:0] in_sh_q;
  logic [7:0][7:0] in_sh_d;
  logic [7:0][7:0] out_sh_q;
  logic [7:0][7:0] out_sh_d;
  logic [7:0]      oe_q;
  logic [7:0]      oe_d;
  logic            ctl_q;
  logic            ctl_d;
  logic [7:0]      dm_d [3][256];

  always_comb begin
    logic [1:0] ob;
    logic [1:0] rb;
    logic [4:0] ns;
    logic [4:0] cc;
    logic [2:0] cb;
    logic [7:0] ent;
    logic [7:0] src;
    logic       msg;
    in_sh_d  = in_sh_q;
    out_sh_d = out_sh_q;
    oe_d     = oe_q;
    ctl_d    = ctl_q;
    dm_d     = dm_q;
    ns       = slot_q + 5'h01;
    ob       = (slot_q == 5'h1F) ? inc3(wbuf_q) : wbuf_q;
    ent      = 8'h00;
    src      = 8'h00;
    msg      = 1'b0;
    rb       = ob;
    cb       = bit_q + 3'h1;
    cc       = (bit_q == 3'h7) ? ns : slot_q;
    for (int k = 0; k < 8; k++) begin
      if (mid) begin
        in_sh_d[k] = {in_sh_q[k][6:0], ser_f[k]};
      end
      if (bit_end) begin
        out_sh_d[k] = {out_sh_q[k][6:0], 1'b0};
      end
      // Next slot's byte fetched one channel ahead to allow for the lookup
      if (slot_end) begin
        dm_d[wbuf_q][{3'(k), slot_q}] = in_sh_q[k];
        ent = cmh_q[{3'(k), ns}];
        src = cml_q[{3'(k), ns}]; // [RULE19]
        msg = ctrl_q[tsw_pkg::CTRL_MSG] || ent[tsw_pkg::CMH_MSG]; // [RULE12] [RULE13]
        if (ent[tsw_pkg::CMH_DLY]) begin // [RULE17] [RULE18]
          rb = inc3(ob); // [RULE1] [RULE2]
        end else if (({1'b0, src[4:0]} + tsw_pkg::VAR_GAP) < {1'b0, ns}) begin
          rb = ob;
        end else begin
          rb = inc3(inc3(ob));
        end
        out_sh_d[k] = msg ? src : dm_q[rb][src]; // [RULE13]
        oe_d[k] = ctrl_q[tsw_pkg::CTRL_MSG] || ent[tsw_pkg::CMH_OE]; // [RULE12] [RULE14]
      end
    end
    // Bit k of channel c carries stream k, channel c+1 [RULE16]
    if (bit_end) begin
      ctl_d = cmh_q[{cb, 5'(cc + 5'h01)}][tsw_pkg::CMH_CTL]; // [RULE15] [RULE20]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      in_sh_q  <= '0;
      out_sh_q <= '0;
      oe_q     <= 8'h00;
      ctl_q    <= 1'b0;
      for (int b = 0; b < 3; b++) begin
        for (int i = 0; i < 256; i++) begin
          dm_q[b][i] <= tsw_pkg::MEM_RST;
        end
      end
    end else if (i_clk_en) begin
      in_sh_q  <= in_sh_d;
      out_sh_q <= out_sh_d;
      oe_q     <= oe_d;
      ctl_q    <= ctl_d;
      dm_q     <= dm_d;
    end
  end

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      o_ser_out[k] = out_sh_q[k][7];
    end
  end

  assign o_ser_oe             = oe_q & {8{ode_f}}; // [RULE14]
  assign o_serial_control_out = ctl_q;

  // Checks
  default clocking cb_sys @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_take;
    i_clk_en && hp_q == tsw_pkg::HP_BUSY && strobe && cnt_q == 9'(ACK_WAIT - 1);
  endsequence

  property p_ack_bound;
    hp_q == tsw_pkg::HP_BUSY |-> cnt_q < 9'(tsw_pkg::ACK_CM_CYC);
  endproperty
  a_ack_bound: assert property (p_ack_bound) else $error("ack too late"); // [RULE5]

  property p_ack_release;
    i_clk_en && o_transfer_ack && !strobe |=> !o_transfer_ack;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack held"); // [RULE3]

  property p_ctrl_wr;
    s_take ##0 (!rw_f && (addr_f & tsw_pkg::CTRL_MASK) == tsw_pkg::CTRL_ADDR)
      |=> ctrl_q == $past(data_f) ##1 o_transfer_ack;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // [RULE7]

  property p_split_wr;
    s_take ##0 (!rw_f && addr_f[5] && ctrl_q[tsw_pkg::CTRL_SPLIT])
      |=> cml_q[$past(midx)] == $past(data_f);
  endproperty
  a_split_wr: assert property (p_split_wr) else $error("split write missed"); // [RULE9]

  property p_hiz;
    !ode_f |-> o_ser_oe == 8'h00;
  endproperty
  a_hiz: assert property (p_hiz) else $error("output driven while disabled"); // [RULE14]

  property p_override;
    i_clk_en && slot_end && ctrl_q[tsw_pkg::CTRL_MSG] |=> oe_q == 8'hFF;
  endproperty
  a_override: assert property (p_override) else $error("override not applied"); // [RULE12]

  property p_buf_rot;
    i_clk_en && slot_end && slot_q == 5'h1F && !fp_rise |=> wbuf_q == inc3($past(wbuf_q));
  endproperty
  a_buf_rot: assert property (p_buf_rot) else $error("buffer not rotated"); // [RULE1]

  property p_ctl_lead;
    i_clk_en && bit_end && bit_q == 3'h7 && slot_q == 5'h1E && !fp_rise
      |=> o_serial_control_out == cmh_q[0][tsw_pkg::CMH_CTL];
  endproperty
  a_ctl_lead: assert property (p_ctl_lead) else $error("control bit misplaced"); // [RULE16]

  property p_data_oe;
    o_data_oe |-> o_transfer_ack && rd_q;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data driven outside read"); // [RULE4]
endmodule
`default_nettype wire

// File: dv/tsw_host_model.sv
// Host microprocessor model for the switch parallel port
`timescale 1ns/100ps
`default_nettype none
module tsw_host_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_transfer_ack,
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  output logic            o_cs_n,
  output logic            o_ds_n,
  output logic            o_rw,
  output logic      [5:0] o_addr,
  output logic      [7:0] o_data
);
  initial begin
    o_cs_n = 1'b1;
    o_ds_n = 1'b1;
    o_rw   = 1'b1;
    o_addr = 6'h3F;
    o_data = 8'hFF;
  end
  // One whole byte cycle; lat is -1 when the answer never comes
  task automatic xfer(input logic rw, input logic [5:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output int lat);
    int n;
    @(posedge i_sys_clk);
    #1;
    o_rw   = rw;
    o_addr = a;
    o_data = wd;
    o_cs_n = 1'b0;
    o_ds_n = 1'b0;
    lat    = 0;
    // Hold everything until the acknowledge, giving up after 400 cycles
    do begin
      @(posedge i_sys_clk);
      lat++;
    end while (i_transfer_ack !== 1'b1 && lat < 400);
    rd = i_data;
    if (lat >= 400 || (rw && i_data_oe !== 1'b1)) lat = -1;
    #1;
    o_cs_n = 1'b1;
    o_ds_n = 1'b1;
    // Released lines show the inverse so stale values cannot pass
    o_addr = ~a;
    o_data = ~wd;
    n = 0;
    while (i_transfer_ack !== 1'b0 && n < 400) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 400) lat = -1;
    repeat (2) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench of the time-slot switch host control
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int BIT_CYC = 8;
  localparam int FRAME   = 256 * BIT_CYC;
  logic       clk;
  logic       resetn;
  logic       clk_en;
  logic       fp;
  logic       global_output_disable;
  logic [7:0] ser_in;
  logic       cs_n;
  logic       ds_n;
  logic       rw;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       data_oe;
  logic       ack;
  logic [7:0] ser_out;
  logic [7:0] ser_oe;
  logic       ctl_out;
  logic [7:0] q;
  int         err_total;
  int         comparisons;
  int         n;
  tsw_core #(.BIT_CYC(BIT_CYC), .ACK_WAIT(4)) i_dut (
    .i_sys_clk(clk), .i_resetn(resetn), .i_clk_en(clk_en), .i_frame_pulse(fp),
    .i_ser_in(ser_in), .i_global_output_disable(global_output_disable), .i_cs_n(cs_n), .i_ds_n(ds_n),
    .i_rw(rw), .i_addr(addr), .i_data(wdata), .o_data(rdata), .o_data_oe(data_oe),
    .o_transfer_ack(ack), .o_ser_out(ser_out), .o_ser_oe(ser_oe),
    .o_serial_control_out(ctl_out));
  tsw_host_model i_host (
    .i_sys_clk(clk), .i_transfer_ack(ack), .i_data(rdata), .i_data_oe(data_oe),
    .o_cs_n(cs_n), .o_ds_n(ds_n), .o_rw(rw), .o_addr(addr), .o_data(wdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    fp = 1'b0;
    forever begin
      repeat (FRAME - 1) @(posedge clk);
      #1 fp = 1'b1;
      @(posedge clk);
      #1 fp = 1'b0;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] d, input int lim);
    int lat;
    i_host.xfer(r, a, d, q, lat);
    chk(16'(lat >= 1 && lat <= lim), 16'h0001);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b0, a, d, tsw_pkg::ACK_CM_CYC);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    acc(1'b1, a, 8'h00, tsw_pkg::ACK_DM_CYC);
    chk({8'h00, q}, {8'h00, exp});
  endtask
  function automatic logic [7:0] ctl(logic sp, logic me, logic [1:0] ms, logic [2:0] st);
    return {sp, me, 1'b0, ms, st};
  endfunction
  // Cycles high over one frame; index 8 selects the control output
  task automatic hi_cycles(input int which);
    n = 0;
    repeat (FRAME) begin
      @(posedge clk);
      if (which == 8) n += int'(ctl_out === 1'b1);
      else n += int'(ser_oe[which] === 1'b1);
    end
  endtask
  // Byte of stream k in its next enabled slot, sampled mid-bit, first bit is bit 7
  task automatic get_byte(input int k);
    n = 0;
    // Skip a slot already under way so the capture starts at its first bit
    while (ser_oe[k] === 1'b1 && n < FRAME) begin
      @(posedge clk);
      n++;
    end
    while (ser_oe[k] !== 1'b1 && n < 2 * FRAME) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int b = 7; b >= 0; b--) begin
      q[b] = ser_out[k];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  task automatic t_ctrl();
    rd(6'h00, tsw_pkg::CTRL_RST);
    wr(6'h00, 8'h9A);
    rd(6'h1C, 8'h9A);
    rd(6'h01, 8'h00);
  endtask
  task automatic t_cm();
    for (int st = 0; st < 8; st += 7) begin
      wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CML, 3'(st)));
      wr(6'h3F, 8'(st * 32 + 31));
      wr(6'h20, 8'(st * 32 + 1));
      wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'(st)));
      rd(6'h25, tsw_pkg::MEM_RST);
      wr(6'h3F, 8'h40);
    end
    for (int st = 0; st < 8; st += 7) begin
      wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CML, 3'(st)));
      rd(6'h3F, 8'(st * 32 + 31));
      rd(6'h20, 8'(st * 32 + 1));
      wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'(st)));
      rd(6'h3F, 8'h40);
    end
  endtask
  task automatic t_dm();
    repeat (3 * FRAME) @(posedge clk);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_DM, 3'h2));
    rd(6'h27, 8'hFF);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_DM, 3'h1));
    wr(6'h27, 8'h33);
    rd(6'h27, 8'h00);
  endtask
  task automatic t_split();
    wr(6'h00, ctl(1'b1, 1'b0, tsw_pkg::MS_CMH, 3'h2));
    rd(6'h27, 8'hFF);
    wr(6'h29, 8'h77);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CML, 3'h2));
    rd(6'h29, 8'h77);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'h2));
    rd(6'h29, 8'h00);
  endtask
  task automatic t_msg();
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CML, 3'h0));
    wr(6'h23, 8'h3C);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'h0));
    wr(6'h23, 8'h05);
    hi_cycles(0);
    chk(16'(n), 16'h0000);
    @(posedge clk);
    #1 global_output_disable = 1'b1;
    repeat (FRAME) @(posedge clk);
    hi_cycles(0);
    chk(16'(n), 16'(8 * BIT_CYC));
    get_byte(0);
    chk({8'h00, q}, 16'h003C);
    // Override makes an all-zero entry drive every slot
    wr(6'h00, ctl(1'b0, 1'b1, tsw_pkg::MS_CMH, 3'h0));
    repeat (FRAME) @(posedge clk);
    hi_cycles(1);
    chk(16'(n), 16'(FRAME));
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'h0));
  endtask
  task automatic t_cst();
    wr(6'h23, 8'h07);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'h4));
    wr(6'h2A, 8'h02);
    // Stream 1 slot 5 fed from stream 2 channel 9, constant delay, driven
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CML, 3'h1));
    wr(6'h25, 8'h49);
    wr(6'h00, ctl(1'b0, 1'b0, tsw_pkg::MS_CMH, 3'h1));
    wr(6'h25, 8'h41);
    repeat (FRAME) @(posedge clk);
    hi_cycles(8);
    chk(16'(n), 16'(2 * BIT_CYC));
    get_byte(1);
    chk({8'h00, q}, 16'h00FF);
  endtask
  // Clock enable low must hold the drive enable of the slot under way
  task automatic t_freeze();
    n = 0;
    while (ser_oe[1] !== 1'b1 && n < 2 * FRAME) begin
      @(posedge clk);
      n++;
    end
    #1 clk_en = 1'b0;
    hi_cycles(1);
    #1 clk_en = 1'b1;
    chk(16'(n), 16'(FRAME));
  endtask
  task automatic test_done();
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    err_total   = 0;
    comparisons = 0;
    resetn      = 1'b0;
    clk_en      = 1'b1;
    global_output_disable         = 1'b0;
    ser_in      = 8'hA5;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    t_ctrl();
    t_cm();
    t_dm();
    t_split();
    t_msg();
    t_cst();
    t_freeze();
    test_done();
  end
  initial begin
    #300000;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
